// ==== verilog/temp_fmt_pkg.sv ====
// Constants shared by the temperature result formatter and its register port.
// Assumes one 250 MHz clock and a register pointer driven by the serial front end.
package temp_fmt_pkg;
   localparam logic [7:0] PTR_LOCAL_HIGH = 8'h00;
   localparam logic [7:0] PTR_REMOTE_HIGH = 8'h01;
   localparam logic [7:0] PTR_CONFIG1_RD = 8'h03;
   localparam logic [7:0] PTR_CONFIG1_WR = 8'h09;
   localparam logic [7:0] PTR_REMOTE_LOW = 8'h10;
   localparam logic [7:0] PTR_LOCAL_LOW = 8'h15;
   localparam int RANGE_BIT = 2;
   localparam logic [7:0] CONFIG1_RESET = 8'h00;
   localparam logic [7:0] RESULT_RESET = 8'h00;
   localparam logic [7:0] STD_MAX = 8'h7F;
   localparam logic [8:0] EXT_OFFSET = 9'h040;
   localparam logic [7:0] EXT_MAX = 8'hFF;
   localparam int FRAC_BITS = 4;
   typedef enum logic [1:0] {CONV_IDLE, CONV_RANGING, CONV_MEASURE} conv_state_t;
endpackage : temp_fmt_pkg

// ==== verilog/temp_code_format.sv ====
// Converts one signed raw temperature into its whole-degree and fraction bytes.
// Assumes the raw sample is twos complement with four fraction bits.
`timescale 1ns/100ps
module temp_code_format #(
   parameter int RAW_W = 13
) (
   input wire logic signed [RAW_W-1:0] raw,
   input wire logic extRange,
   output logic [7:0] highByte,
   output logic [7:0] lowByte
);
   logic signed [RAW_W-5:0] whole;
   logic signed [RAW_W-4:0] shifted;

   always_comb begin
      whole = raw[RAW_W-1:temp_fmt_pkg::FRAC_BITS];
      shifted = {whole[RAW_W-5], whole} + $signed({1'b0, temp_fmt_pkg::EXT_OFFSET});
      lowByte = {raw[temp_fmt_pkg::FRAC_BITS-1:0], 4'h0};
      if (extRange) begin
         if (shifted < 0) begin
            highByte = 8'h00;
            lowByte = 8'h00;
         end else if (shifted > $signed({1'b0, temp_fmt_pkg::EXT_MAX})) begin
            highByte = temp_fmt_pkg::EXT_MAX;
            lowByte = 8'hF0;
         end else begin
            highByte = shifted[7:0];
         end
      end else begin
         if (whole < 0) begin
            highByte = 8'h00;
            lowByte = 8'h00;
         end else if (whole > $signed({1'b0, temp_fmt_pkg::STD_MAX})) begin
            highByte = temp_fmt_pkg::STD_MAX;
            lowByte = 8'hF0;
         end else begin
            highByte = whole[7:0];
         end
      end
   end
endmodule : temp_code_format

// ==== verilog/temp_result_formatter.sv ====
// Temperature result registers for a local and a remote channel.
// Assumes a serial front end presents pointer, read and write strobes in the clk domain.
`timescale 1ns/100ps
// Functional notes
// - Default range reports 0 to 127 degrees in standard binary.
// - Standard format stores high byte zero below zero degrees.
// - Standard format saturates high byte at 127.
// - Configuration bit 2 set selects the extended range and format.
// - Range change leaves stored data alone; applies from next conversion.
// - Extended format adds 64 to the whole-degree value.
// - Extended format covers -64 to +191 degrees, codes 00 to FF.
// - Each channel holds two bytes, same layout for local and remote.
// - High byte carries one degree per count.
// - Low byte upper nibble is sixteenths, lower nibble zero.
// - Resolution is fixed at one sixteenth degree.
// - Current range selection runs at start of each conversion.
// - Alarm asserts when a temperature passes high or low limit.
// - Thermal flag asserts when a temperature passes thermal limits.
// - Alarm and thermal flag only pull low or release.
// - Local high byte read at pointer 00, read only, resets zero.
// - Remote high byte read at pointer 01, read only, resets zero.
module temp_result_formatter #(
   parameter int RAW_W = 13
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [7:0] regPtr,
   input wire logic regWrite,
   input wire logic [7:0] regWdata,
   input wire logic regRead,
   output logic [7:0] regRdata,
   input wire logic convStart,
   input wire logic convChannel,
   input wire logic rangingDone,
   input wire logic sampleValid,
   input wire logic signed [RAW_W-1:0] sampleRaw,
   output logic rangingStart,
   output logic convBusy,
   input wire logic alarmHit,
   input wire logic thermHit,
   output logic alarmOut,
   output logic alarmOe,
   output logic thermOut,
   output logic thermOe
);
   logic [7:0] config1_q, config1_d;
   logic rangeLatched_q, rangeLatched_d;
   logic channel_q, channel_d;
   temp_fmt_pkg::conv_state_t state_q, state_d;
   logic [7:0] resHigh_q [2];
   logic [7:0] resLow_q [2];
   logic [7:0] resHigh_d [2];
   logic [7:0] resLow_d [2];
   logic [7:0] fmtHigh, fmtLow;
   logic [7:0] rdata_d, rdata_q;
   logic alarm_q, alarm_d, therm_q, therm_d;

   // Configuration and conversion sequencing.
   always_comb begin
      config1_d = config1_q;
      rangeLatched_d = rangeLatched_q;
      channel_d = channel_q;
      state_d = state_q;
      rangingStart = 1'b0;
      if (regWrite && regPtr == temp_fmt_pkg::PTR_CONFIG1_WR) begin
         config1_d = regWdata;
      end
      case (state_q)
         temp_fmt_pkg::CONV_IDLE: begin
            if (convStart) begin
               rangeLatched_d = config1_q[temp_fmt_pkg::RANGE_BIT];
               channel_d = convChannel;
               rangingStart = 1'b1;
               state_d = temp_fmt_pkg::CONV_RANGING;
            end
         end
         temp_fmt_pkg::CONV_RANGING: begin
            if (rangingDone) begin
               state_d = temp_fmt_pkg::CONV_MEASURE;
            end
         end
         temp_fmt_pkg::CONV_MEASURE: begin
            if (sampleValid) begin
               state_d = temp_fmt_pkg::CONV_IDLE;
            end
         end
         default: state_d = temp_fmt_pkg::CONV_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         config1_q <= temp_fmt_pkg::CONFIG1_RESET;
         rangeLatched_q <= 1'b0;
         channel_q <= 1'b0;
         state_q <= temp_fmt_pkg::CONV_IDLE;
      end else begin
         config1_q <= config1_d;
         rangeLatched_q <= rangeLatched_d;
         channel_q <= channel_d;
         state_q <= state_d;
      end
   end

   assign convBusy = (state_q != temp_fmt_pkg::CONV_IDLE);

   temp_code_format #(
      .RAW_W(RAW_W)
   ) u_format (
      .raw(sampleRaw),
      .extRange(rangeLatched_q),
      .highByte(fmtHigh),
      .lowByte(fmtLow)
   );

   // Result storage: index 0 is local, index 1 is remote.
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_chan
         always_comb begin
            resHigh_d[ch] = resHigh_q[ch];
            resLow_d[ch] = resLow_q[ch];
            if (state_q == temp_fmt_pkg::CONV_MEASURE && sampleValid && channel_q == 1'(ch)) begin
               resHigh_d[ch] = fmtHigh;
               resLow_d[ch] = fmtLow;
            end
         end
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               resHigh_q[ch] <= temp_fmt_pkg::RESULT_RESET;
               resLow_q[ch] <= temp_fmt_pkg::RESULT_RESET;
            end else begin
               resHigh_q[ch] <= resHigh_d[ch];
               resLow_q[ch] <= resLow_d[ch];
            end
         end
      end
   endgenerate

   // Read data register; writes to result pointers are ignored.
   always_comb begin
      rdata_d = rdata_q;
      if (regRead) begin
         case (regPtr)
            temp_fmt_pkg::PTR_LOCAL_HIGH: rdata_d = resHigh_q[0];
            temp_fmt_pkg::PTR_REMOTE_HIGH: rdata_d = resHigh_q[1];
            temp_fmt_pkg::PTR_LOCAL_LOW: rdata_d = resLow_q[0];
            temp_fmt_pkg::PTR_REMOTE_LOW: rdata_d = resLow_q[1];
            temp_fmt_pkg::PTR_CONFIG1_RD: rdata_d = config1_q;
            default: rdata_d = 8'h00;
         endcase
      end
   end

   // Open-drain flags: output is always low, only the enable moves.
   always_comb begin
      alarm_d = alarmHit;
      therm_d = thermHit;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_q <= 8'h00;
         alarm_q <= 1'b0;
         therm_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         alarm_q <= alarm_d;
         therm_q <= therm_d;
      end
   end

   assign regRdata = rdata_q;
   assign alarmOut = 1'b0;
   assign thermOut = 1'b0;
   assign alarmOe = alarm_q;
   assign thermOe = therm_q;

   property p_ranging_first;
      @(posedge clk) disable iff (!arst_n)
         (state_q == temp_fmt_pkg::CONV_IDLE && convStart) |-> rangingStart ##1
            (state_q == temp_fmt_pkg::CONV_RANGING);
   endproperty
   a_ranging_first: assert property (p_ranging_first) else $error("Ranging not started.");

   property p_range_hold;
      @(posedge clk) disable iff (!arst_n)
         (state_q != temp_fmt_pkg::CONV_IDLE) |=> $stable(rangeLatched_q) || state_q == temp_fmt_pkg::CONV_IDLE;
   endproperty
   a_range_hold: assert property (p_range_hold) else $error("Range changed mid conversion.");

   property p_std_high;
      @(posedge clk) disable iff (!arst_n)
         !rangeLatched_q |-> fmtHigh <= temp_fmt_pkg::STD_MAX;
   endproperty
   a_std_high: assert property (p_std_high) else $error("Standard byte above 127.");

   property p_std_neg;
      @(posedge clk) disable iff (!arst_n)
         (!rangeLatched_q && sampleRaw < 0) |-> fmtHigh == 8'h00;
   endproperty
   a_std_neg: assert property (p_std_neg) else $error("Negative not zero.");

   property p_low_nibble;
      @(posedge clk) disable iff (!arst_n) resLow_q[0][3:0] == 4'h0 && resLow_q[1][3:0] == 4'h0;
   endproperty
   a_low_nibble: assert property (p_low_nibble) else $error("Low nibble not zero.");

   property p_pair_update;
      @(posedge clk) disable iff (!arst_n)
         (state_q == temp_fmt_pkg::CONV_MEASURE && sampleValid && !channel_q) |=>
            resHigh_q[0] == $past(fmtHigh) && resLow_q[0] == $past(fmtLow);
   endproperty
   a_pair_update: assert property (p_pair_update) else $error("Bytes not updated together.");

   property p_ext_offset;
      @(posedge clk) disable iff (!arst_n)
         (rangeLatched_q && sampleRaw == 0) |-> fmtHigh == 8'h40;
   endproperty
   a_ext_offset: assert property (p_ext_offset) else $error("Offset not 64.");

   property p_read_local;
      @(posedge clk) disable iff (!arst_n)
         (regRead && regPtr == temp_fmt_pkg::PTR_LOCAL_HIGH) |=> regRdata == $past(resHigh_q[0]);
   endproperty
   a_read_local: assert property (p_read_local) else $error("Local read wrong.");

   property p_read_remote;
      @(posedge clk) disable iff (!arst_n)
         (regRead && regPtr == temp_fmt_pkg::PTR_REMOTE_HIGH) |=> regRdata == $past(resHigh_q[1]);
   endproperty
   a_read_remote: assert property (p_read_remote) else $error("Remote read wrong.");

   property p_alarm;
      @(posedge clk) disable iff (!arst_n) alarmHit |=> alarmOe && !alarmOut;
   endproperty
   a_alarm: assert property (p_alarm) else $error("Alarm not pulled low.");

   property p_therm;
      @(posedge clk) disable iff (!arst_n) thermHit |=> thermOe && !thermOut;
   endproperty
   a_therm: assert property (p_therm) else $error("Thermal flag not pulled low.");

   // The flag pins never drive high, so several parts can share one pulled-up line.
   property p_open_drain;
      @(posedge clk) disable iff (!arst_n) !alarmOut && !thermOut;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("Flag output driven high.");

   property p_pair_update_remote;
      @(posedge clk) disable iff (!arst_n)
         (state_q == temp_fmt_pkg::CONV_MEASURE && sampleValid && channel_q) |=>
            resHigh_q[1] == $past(fmtHigh) && resLow_q[1] == $past(fmtLow);
   endproperty
   a_pair_update_remote: assert property (p_pair_update_remote) else $error("Remote bytes not paired.");

   // A write to a result pointer must leave the stored byte untouched.
   property p_local_read_only;
      @(posedge clk) disable iff (!arst_n)
         (regWrite && regPtr == temp_fmt_pkg::PTR_LOCAL_HIGH &&
            !(state_q == temp_fmt_pkg::CONV_MEASURE && sampleValid)) |=> $stable(resHigh_q[0]);
   endproperty
   a_local_read_only: assert property (p_local_read_only) else $error("Local high byte written.");

   property p_remote_read_only;
      @(posedge clk) disable iff (!arst_n)
         (regWrite && regPtr == temp_fmt_pkg::PTR_REMOTE_HIGH &&
            !(state_q == temp_fmt_pkg::CONV_MEASURE && sampleValid)) |=> $stable(resHigh_q[1]);
   endproperty
   a_remote_read_only: assert property (p_remote_read_only) else $error("Remote high byte written.");

   property p_range_select;
      @(posedge clk) disable iff (!arst_n)
         (state_q == temp_fmt_pkg::CONV_IDLE && convStart) |=>
            rangeLatched_q == $past(config1_q[temp_fmt_pkg::RANGE_BIT]);
   endproperty
   a_range_select: assert property (p_range_select) else $error("Range bit not latched at start.");

   property p_config_read;
      @(posedge clk) disable iff (!arst_n)
         (regRead && regPtr == temp_fmt_pkg::PTR_CONFIG1_RD) |=> regRdata == $past(config1_q);
   endproperty
   a_config_read: assert property (p_config_read) else $error("Configuration read wrong.");

   // Inside the standard range the bytes are the raw code split at the binary point.
   property p_fraction;
      @(posedge clk) disable iff (!arst_n)
         (!rangeLatched_q && sampleRaw[RAW_W-1:temp_fmt_pkg::FRAC_BITS+7] == '0) |->
            fmtLow[7:4] == sampleRaw[3:0] && fmtHigh == 8'(sampleRaw[RAW_W-1:temp_fmt_pkg::FRAC_BITS]);
   endproperty
   a_fraction: assert property (p_fraction) else $error("Fraction or whole byte wrong.");

   property p_no_restart;
      @(posedge clk) disable iff (!arst_n) (state_q != temp_fmt_pkg::CONV_IDLE) |-> !rangingStart;
   endproperty
   a_no_restart: assert property (p_no_restart) else $error("Ranging restarted while busy.");

   c_ext_conv: cover property (@(posedge clk) disable iff (!arst_n)
      rangeLatched_q && sampleValid && state_q == temp_fmt_pkg::CONV_MEASURE);
   c_remote_conv: cover property (@(posedge clk) disable iff (!arst_n)
      channel_q && sampleValid && state_q == temp_fmt_pkg::CONV_MEASURE);
   c_therm: cover property (@(posedge clk) disable iff (!arst_n) thermOe);
   c_std_clamp: cover property (@(posedge clk) disable iff (!arst_n)
      !rangeLatched_q && sampleValid && state_q == temp_fmt_pkg::CONV_MEASURE && fmtHigh == temp_fmt_pkg::STD_MAX);
   c_range_change: cover property (@(posedge clk) disable iff (!arst_n)
      regWrite && regPtr == temp_fmt_pkg::PTR_CONFIG1_WR && convBusy);
endmodule : temp_result_formatter

// ==== test/front_end_model.sv ====
// Measurement front end that answers the conversion handshake.
// Assumes the bench sets the answer delay and the next raw sample before each start.
`timescale 1ns/100ps
module front_end_model #(
   parameter int RAW_W = 13
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic rangingStart,
   input wire logic [7:0] lag,
   input wire logic signed [RAW_W-1:0] nextRaw,
   output logic rangingDone,
   output logic sampleValid,
   output logic signed [RAW_W-1:0] sampleRaw
);
   initial begin
      rangingDone = 1'b0;
      sampleValid = 1'b0;
      sampleRaw = '0;
      forever begin
         @(posedge clk);
         if (arst_n && rangingStart) begin
            repeat (lag) @(posedge clk);
            #1 rangingDone = 1'b1;
            @(posedge clk);
            #1 rangingDone = 1'b0;
            // Keep every change one step after an edge, also when there is no lag.
            if (lag != 8'h00) begin
               repeat (lag) @(posedge clk);
               #1;
            end
            sampleValid = 1'b1;
            sampleRaw = nextRaw;
            @(posedge clk);
            #1 sampleValid = 1'b0;
            // The sample bus does not hold its value once the strobe drops.
            sampleRaw = ~nextRaw;
         end
      end
   end
endmodule : front_end_model

// ==== test/tb_temp_result_formatter.sv ====
// Self-checking bench for the temperature result formatter.
// Assumes the front end model answers conversions while the bench plays the register host.
`timescale 1ns/100ps
module tb_temp_result_formatter;
   logic clk, arst_n, regWrite, regRead, convStart, convChannel, alarmHit, thermHit;
   logic [7:0] regPtr, regWdata, regRdata, lag, rd;
   logic rangingDone, sampleValid, rangingStart, convBusy, alarmOut, alarmOe, thermOut, thermOe;
   logic signed [12:0] nextRaw, sampleRaw;
   int fail_count = 0;
   int cmp_count = 0;
   int raws [10] = '{-16, 0, 408, 2047, 2048, 2400, -1024, -1040, 3071, 3072};

   temp_result_formatter #(.RAW_W(13)) dut (.clk(clk), .arst_n(arst_n), .regPtr(regPtr),
      .regWrite(regWrite), .regWdata(regWdata), .regRead(regRead), .regRdata(regRdata),
      .convStart(convStart), .convChannel(convChannel), .rangingDone(rangingDone),
      .sampleValid(sampleValid), .sampleRaw(sampleRaw), .rangingStart(rangingStart),
      .convBusy(convBusy), .alarmHit(alarmHit), .thermHit(thermHit), .alarmOut(alarmOut),
      .alarmOe(alarmOe), .thermOut(thermOut), .thermOe(thermOe));
   front_end_model #(.RAW_W(13)) fe (.clk(clk), .arst_n(arst_n), .rangingStart(rangingStart),
      .lag(lag), .nextRaw(nextRaw), .rangingDone(rangingDone), .sampleValid(sampleValid),
      .sampleRaw(sampleRaw));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic reg_read(input logic [7:0] ptr, output logic [7:0] data);
      @(posedge clk);
      #1 regPtr = ptr;
      regRead = 1'b1;
      @(posedge clk);
      #1 regRead = 1'b0;
      data = regRdata;
   endtask : reg_read

   task automatic reg_write(input logic [7:0] ptr, input logic [7:0] data);
      @(posedge clk);
      #1 regPtr = ptr;
      regWdata = data;
      regWrite = 1'b1;
      @(posedge clk);
      #1 regWrite = 1'b0;
   endtask : reg_write

   task automatic start_conv(input logic ch, input int raw, input int dly);
      @(posedge clk);
      #1 convChannel = ch;
      nextRaw = 13'(raw);
      lag = 8'(dly);
      convStart = 1'b1;
      #1 check(rangingStart, 1'b1);
      @(posedge clk);
      #1 convStart = 1'b0;
      check(convBusy, 1'b1);
   endtask : start_conv

   task automatic wait_done;
      int n;
      n = 0;
      while (convBusy !== 1'b0 && n < 500) begin
         @(posedge clk);
         #1 n++;
      end
      if (n >= 500) fail_count++;
   endtask : wait_done

   // High byte in the top half, low byte in the bottom half.
   function automatic logic [15:0] exp_bytes(input int raw, input logic ext);
      int w;
      w = (raw >>> 4) + (ext ? 64 : 0);
      if (w < 0) return 16'h0000;
      if (w > (ext ? 255 : 127)) return ext ? 16'hFFF0 : 16'h7FF0;
      return {w[7:0], raw[3:0], 4'h0};
   endfunction : exp_bytes

   task automatic check_chan(input logic ch, input logic [15:0] exp);
      logic [7:0] hi, lo;
      reg_read(ch ? temp_fmt_pkg::PTR_REMOTE_HIGH : temp_fmt_pkg::PTR_LOCAL_HIGH, hi);
      reg_read(ch ? temp_fmt_pkg::PTR_REMOTE_LOW : temp_fmt_pkg::PTR_LOCAL_LOW, lo);
      check({hi, lo}, exp);
   endtask : check_chan

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_sim

   initial begin
      arst_n = 1'b0;
      regPtr = 8'h00;
      regWdata = 8'h00;
      {regWrite, regRead, convStart, convChannel, alarmHit, thermHit} = 6'h00;
      lag = 8'h00;
      nextRaw = '0;
      repeat (10) @(posedge clk);
      #1 arst_n = 1'b1;
      reg_read(temp_fmt_pkg::PTR_CONFIG1_RD, rd);
      check(rd, temp_fmt_pkg::CONFIG1_RESET);
      for (int ch = 0; ch < 2; ch++) begin
         reg_write(8'(ch), 8'h5A);
         check_chan(ch[0], 16'h0000);
      end
      reg_read(8'h77, rd);
      check(rd, 8'h00);
      for (int ext = 0; ext < 2; ext++) begin
         reg_write(temp_fmt_pkg::PTR_CONFIG1_WR, ext ? 8'h04 : 8'h00);
         reg_read(temp_fmt_pkg::PTR_CONFIG1_RD, rd);
         check(rd, ext ? 8'h04 : 8'h00);
         if (ext == 1) check_chan(1'b1, 16'h7FF0);
         for (int i = 0; i < 10; i++) begin
            for (int ch = 0; ch < 2; ch++) begin
               start_conv(ch[0], raws[i], i * 3);
               wait_done();
               check_chan(ch[0], exp_bytes(raws[i], ext[0]));
            end
         end
      end
      start_conv(1'b0, 0, 20);
      reg_write(temp_fmt_pkg::PTR_CONFIG1_WR, 8'h00);
      wait_done();
      check_chan(1'b0, 16'h4000);
      start_conv(1'b0, 0, 0);
      wait_done();
      check_chan(1'b0, 16'h0000);
      @(posedge clk);
      #1 alarmHit = 1'b1;
      repeat (2) @(posedge clk);
      #1 check({alarmOe, alarmOut, thermOe, thermOut}, 4'b1000);
      alarmHit = 1'b0;
      thermHit = 1'b1;
      repeat (2) @(posedge clk);
      #1 check({alarmOe, alarmOut, thermOe, thermOut}, 4'b0010);
      end_sim();
   end

   // About forty conversions of at most seventy cycles each; this span is many times that.
   initial begin
      #200000;
      fail_count++;
      end_sim();
   end
endmodule : tb_temp_result_formatter
